// file: src/pcu_pkg.sv
// Contract
// - Arm control value 0 cancels, 1 starts one-shot, 2 starts continuous capture.
// - One-shot stops after the first latched position and ignores later edges.
// - Continuous mode stays armed and latches on every qualifying edge.
// - Edge select 0 triggers on falling edge, 1 on rising edge.
// - A 16-bit unsigned tally counts up once per capture event.
// - The tally clears to zero whenever the unit is armed; a capture in the arming cycle sets it to 1 instead.
// - Each capture stores actual position at the trigger as signed 32 bits.
// - After position setting or homing the stored position is rebased.
// - A completed capture sets bit 0 of the read-only done flags word.
package pcu_pkg;

  // Parameter addresses on the fieldbus side
  localparam logic [15:0] ADDR_DONE_FLAGS = 16'h0a02;
  localparam logic [15:0] ADDR_EDGE_SELECT = 16'h0a04;
  localparam logic [15:0] ADDR_ARM_CONTROL = 16'h0a08;
  localparam logic [15:0] ADDR_CAPT_POS = 16'h0a0c;
  localparam logic [15:0] ADDR_EVENT_TALLY = 16'h0a10;

  // Arm control encodings
  localparam logic [15:0] ARM_STOP = 16'h0000;
  localparam logic [15:0] ARM_ONCE = 16'h0001;
  localparam logic [15:0] ARM_CONT = 16'h0002;

  // Edge select encodings
  localparam logic [15:0] EDGE_FALL = 16'h0000;
  localparam logic [15:0] EDGE_RISE = 16'h0001;

  // Field positions, reset values and tally step
  localparam int DONE_BIT_UNIT1 = 0;
  localparam logic EDGE_SEL_RST = 1'b0;
  localparam logic [31:0] CAPT_POS_RST = 32'h0000_0000;
  localparam logic [15:0] TALLY_RST = 16'h0000;
  localparam logic [15:0] DONE_RST = 16'h0000;
  localparam logic [15:0] TALLY_STEP = 16'h0001;

  // Capture mode
  typedef enum logic [1:0] {
    PCU_IDLE,
    PCU_ONCE,
    PCU_CONT
  } pcu_mode_t;

  // One parameter access request
  typedef struct packed {
    logic [15:0] addr;
    logic wr;
    logic rd;
    logic [31:0] wdata;
  } pcu_req_t;

  // Read answer
  typedef struct packed {
    logic valid;
    logic [31:0] data;
  } pcu_rsp_t;

  // Position source from the drive's tracking
  typedef struct packed {
    logic signed [31:0] actual;
    logic rebase;
    logic signed [31:0] delta;
  } pcu_pos_t;

endpackage : pcu_pkg

// file: src/pcu_edge_sync.sv
`timescale 1ns/1ps
`default_nettype none
module pcu_edge_sync (
  input wire logic clk,
  input wire logic rst,
  input wire logic pin,
  output logic rise,
  output logic fall
);

  logic meta_ff;
  logic sync_ff;
  logic prev_ff;

  // Two-stage synchroniser; first stage feeds only the second
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
      prev_ff <= 1'b0;
    end else begin
      meta_ff <= pin;
      sync_ff <= meta_ff;
      prev_ff <= sync_ff;
    end
  end

  // Compare current with previous sample, one pulse per transition
  assign rise = sync_ff & ~prev_ff;
  assign fall = ~sync_ff & prev_ff;

endmodule : pcu_edge_sync
`default_nettype wire

// file: src/pcu_top.sv
`timescale 1ns/1ps
`default_nettype none
module pcu_top (
  input wire logic CLOCK,
  input wire logic SYS_RST,
  input wire logic CAPTURE_INPUT_LINE,
  input wire pcu_pkg::pcu_pos_t POS,
  input wire pcu_pkg::pcu_req_t REQ,
  output pcu_pkg::pcu_rsp_t RSP,
  output logic CAPTURE_ARMED,
  output logic CAPTURE_STB
);

  logic edge_rise;
  logic edge_fall;
  logic edge_sel_ff;
  pcu_pkg::pcu_mode_t mode_ff;
  pcu_pkg::pcu_mode_t nxt_mode;
  logic signed [31:0] capt_pos_ff;
  logic [15:0] tally_ff;
  logic [15:0] done_ff;
  logic trig;
  logic hit;
  logic arm_wr;
  logic arm_start;
  logic edge_wr;
  pcu_pkg::pcu_rsp_t rsp_ff;
  logic armed_ff;
  logic stb_ff;

  // Pin synchroniser and edge detector
  pcu_edge_sync u_sync (
    .clk(CLOCK),
    .rst(SYS_RST),
    .pin(CAPTURE_INPUT_LINE),
    .rise(edge_rise),
    .fall(edge_fall)
  );

  // Write decode; illegal values are ignored so the old setting stays
  assign arm_wr = REQ.wr && (REQ.addr == pcu_pkg::ADDR_ARM_CONTROL);
  assign edge_wr = REQ.wr && (REQ.addr == pcu_pkg::ADDR_EDGE_SELECT);
  assign arm_start = arm_wr && ((REQ.wdata[15:0] == pcu_pkg::ARM_ONCE) ||
                                (REQ.wdata[15:0] == pcu_pkg::ARM_CONT));

  // Qualifying edge per the selected polarity
  assign trig = edge_sel_ff ? edge_rise : edge_fall;

  // Capture happens only while armed, judged on the mode before any write
  assign hit = trig && (mode_ff != pcu_pkg::PCU_IDLE);

  // Edge select register
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      edge_sel_ff <= pcu_pkg::EDGE_SEL_RST;
    end else if (edge_wr && (REQ.wdata[15:0] == pcu_pkg::EDGE_FALL)) begin
      edge_sel_ff <= 1'b0;
    end else if (edge_wr && (REQ.wdata[15:0] == pcu_pkg::EDGE_RISE)) begin
      edge_sel_ff <= 1'b1;
    end
  end

  // Next mode: a host write beats the one-shot self-stop
  always_comb begin
    nxt_mode = mode_ff;
    if (hit && (mode_ff == pcu_pkg::PCU_ONCE)) begin
      nxt_mode = pcu_pkg::PCU_IDLE;
    end
    if (arm_wr) begin
      case (REQ.wdata[15:0])
        pcu_pkg::ARM_STOP: begin
          nxt_mode = pcu_pkg::PCU_IDLE;
        end
        pcu_pkg::ARM_ONCE: begin
          nxt_mode = pcu_pkg::PCU_ONCE;
        end
        pcu_pkg::ARM_CONT: begin
          nxt_mode = pcu_pkg::PCU_CONT;
        end
        default: begin
          nxt_mode = nxt_mode;
        end
      endcase
    end
  end

  // Mode register
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      mode_ff <= pcu_pkg::PCU_IDLE;
    end else begin
      mode_ff <= nxt_mode;
    end
  end

  // Captured position; a fresh capture wins over a rebase in the same cycle
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      capt_pos_ff <= pcu_pkg::CAPT_POS_RST;
    end else if (hit) begin
      capt_pos_ff <= POS.actual;
    end else if (POS.rebase) begin
      capt_pos_ff <= capt_pos_ff + POS.delta;
    end
  end

  // Event tally; a capture in the arming cycle counts as the first event
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      tally_ff <= pcu_pkg::TALLY_RST;
    end else if (arm_start) begin
      tally_ff <= hit ? pcu_pkg::TALLY_STEP : pcu_pkg::TALLY_RST;
    end else if (hit) begin
      tally_ff <= tally_ff + pcu_pkg::TALLY_STEP;
    end
  end

  // Done flag: cleared on arming, but a capture in that cycle wins
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      done_ff <= pcu_pkg::DONE_RST;
    end else if (hit) begin
      done_ff[pcu_pkg::DONE_BIT_UNIT1] <= 1'b1;
    end else if (arm_start) begin
      done_ff[pcu_pkg::DONE_BIT_UNIT1] <= 1'b0;
    end
  end

  // Read answer one cycle after the request; unmapped reads give zero
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      rsp_ff <= '0;
    end else begin
      rsp_ff.valid <= REQ.rd;
      rsp_ff.data <= 32'h0000_0000;
      if (REQ.rd) begin
        case (REQ.addr)
          pcu_pkg::ADDR_DONE_FLAGS: begin
            rsp_ff.data <= {16'h0000, done_ff};
          end
          pcu_pkg::ADDR_EDGE_SELECT: begin
            rsp_ff.data <= {31'h0000_0000, edge_sel_ff};
          end
          pcu_pkg::ADDR_ARM_CONTROL: begin
            case (mode_ff)
              pcu_pkg::PCU_ONCE: begin
                rsp_ff.data <= {16'h0000, pcu_pkg::ARM_ONCE};
              end
              pcu_pkg::PCU_CONT: begin
                rsp_ff.data <= {16'h0000, pcu_pkg::ARM_CONT};
              end
              default: begin
                rsp_ff.data <= {16'h0000, pcu_pkg::ARM_STOP};
              end
            endcase
          end
          pcu_pkg::ADDR_CAPT_POS: begin
            rsp_ff.data <= capt_pos_ff;
          end
          pcu_pkg::ADDR_EVENT_TALLY: begin
            rsp_ff.data <= {16'h0000, tally_ff};
          end
          default: begin
            rsp_ff.data <= 32'h0000_0000;
          end
        endcase
      end
    end
  end

  // Status outputs straight from flops
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      armed_ff <= 1'b0;
      stb_ff <= 1'b0;
    end else begin
      armed_ff <= (nxt_mode != pcu_pkg::PCU_IDLE);
      stb_ff <= hit;
    end
  end

  assign RSP = rsp_ff;
  assign CAPTURE_ARMED = armed_ff;
  assign CAPTURE_STB = stb_ff;

endmodule : pcu_top
`default_nettype wire

// file: tb/pcu_top_props.sv
`timescale 1ns/1ps
`default_nettype none
module pcu_top_props (
  input wire logic CLOCK,
  input wire logic SYS_RST,
  input wire logic CAPTURE_INPUT_LINE,
  input wire pcu_pkg::pcu_pos_t POS,
  input wire pcu_pkg::pcu_req_t REQ,
  input wire pcu_pkg::pcu_rsp_t RSP,
  input wire logic CAPTURE_ARMED,
  input wire logic CAPTURE_STB
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);
  // Arm write decode
  wire logic arm_wr = REQ.wr && REQ.addr == pcu_pkg::ADDR_ARM_CONTROL;
  rd_answer_a:
    assert property (REQ.rd |=> RSP.valid) else $error("read not answered");
  rsp_quiet_a:
    assert property (!REQ.rd |=> !RSP.valid && RSP.data == 32'h0) else $error("stray answer");
  arm_once_a:
    assert property (arm_wr && REQ.wdata == 32'h1 |=> CAPTURE_ARMED) else $error("once not armed");
  arm_stop_a:
    assert property (arm_wr && REQ.wdata == 32'h0 |=> !CAPTURE_ARMED) else $error("stop ignored");
  cont_stays_a:
    assert property (arm_wr && REQ.wdata == 32'h2 ##1 (!arm_wr)[*3] |-> CAPTURE_ARMED)
      else $error("continuous dropped");
  stb_armed_a:
    assert property (CAPTURE_STB |-> $past(CAPTURE_ARMED)) else $error("capture while stopped");
  stb_single_a:
    assert property (CAPTURE_STB |=> !CAPTURE_STB) else $error("double capture");
  pin_quiet_a:
    assert property (($stable(CAPTURE_INPUT_LINE))[*4] |=> !CAPTURE_STB) else $error("capture without edge");
  stay_idle_a:
    assert property (!CAPTURE_ARMED && !arm_wr |=> !CAPTURE_ARMED) else $error("rearmed by itself");
endmodule : pcu_top_props
bind pcu_top pcu_top_props pcu_top_props_inst (.CLOCK(CLOCK), .SYS_RST(SYS_RST),
  .CAPTURE_INPUT_LINE(CAPTURE_INPUT_LINE), .POS(POS), .REQ(REQ), .RSP(RSP),
  .CAPTURE_ARMED(CAPTURE_ARMED), .CAPTURE_STB(CAPTURE_STB));
`default_nettype wire

// file: tb/pcu_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
module pcu_pin_model (
  input wire logic lvl,
  output logic CAPTURE_INPUT_LINE
);
  // Sensor pin moves off the clock edge, so the synchroniser sees it unaligned
  initial CAPTURE_INPUT_LINE = 1'b0;
  always @(lvl) CAPTURE_INPUT_LINE <= #13 lvl;
endmodule : pcu_pin_model
`default_nettype wire

// file: tb/pcu_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module pcu_top_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic lvl = 1'b0;
  logic pin;
  pcu_pkg::pcu_pos_t pos = '0;
  pcu_pkg::pcu_req_t req = '0;
  pcu_pkg::pcu_rsp_t rsp;
  logic armed;
  logic stb;
  int n_mismatch = 0;
  int compares = 0;
  int n_stb = 0;
  logic [31:0] seed = 32'h16;
  logic [31:0] p;
  logic [31:0] q;
  // 20 MHz clock
  always #25 clk = ~clk;
  pcu_pin_model pcu_pin_model_inst (.lvl(lvl), .CAPTURE_INPUT_LINE(pin));
  pcu_top pcu_top_inst (.CLOCK(clk), .SYS_RST(rst), .CAPTURE_INPUT_LINE(pin), .POS(pos),
    .REQ(req), .RSP(rsp), .CAPTURE_ARMED(armed), .CAPTURE_STB(stb));
  // Strobes counted mid-cycle, away from the edge that launches them
  always @(negedge clk) begin
    if (stb === 1'b1) n_stb++;
  end
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task chk(string w, logic [32:0] e, logic [32:0] g);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %s exp %h got %h", w, e, g);
    end
  endtask : chk
  task wr(logic [15:0] a, logic [31:0] d);
    @(negedge clk) req <= '{a, 1'b1, 1'b0, d};
    @(negedge clk) req <= '0;
  endtask : wr
  // Answer is looked at in the one cycle it stands
  task rd(string w, logic [15:0] a, logic [31:0] e);
    @(negedge clk) req <= '{a, 1'b0, 1'b1, 32'h0};
    @(negedge clk) req <= '0;
    chk(w, {1'b1, e}, rsp);
  endtask : rd
  // Opposite edge first, then the chosen one; position held across both
  task trig(logic s, logic [31:0] at);
    pos.actual <= at;
    lvl <= ~s;
    repeat (6) @(negedge clk);
    lvl <= s;
    repeat (6) @(negedge clk);
  endtask : trig
  task close_out();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : close_out
  initial begin
    repeat (3) @(negedge clk);
    rst <= 1'b0;
    rd("edge", pcu_pkg::ADDR_EDGE_SELECT, 32'h0);
    rd("tally", pcu_pkg::ADDR_EVENT_TALLY, 32'h0);
    rd("done", pcu_pkg::ADDR_DONE_FLAGS, 32'h0);
    rd("unmapped", 16'h0a06, 32'h0);
    chk("armed", 33'h0, armed);
    chk("strobes", 33'h0, n_stb);
    wr(pcu_pkg::ADDR_CAPT_POS, rnd());
    rd("pos", pcu_pkg::ADDR_CAPT_POS, 32'h0);
    $display("test reset done");
    for (int s = 0; s < 2; s++) begin
      p = rnd();
      wr(pcu_pkg::ADDR_EDGE_SELECT, 32'(s));
      wr(pcu_pkg::ADDR_ARM_CONTROL, 32'(pcu_pkg::ARM_ONCE));
      chk("armed", 33'h1, armed);
      rd("edge", pcu_pkg::ADDR_EDGE_SELECT, 32'(s));
      rd("arm", pcu_pkg::ADDR_ARM_CONTROL, 32'h1);
      rd("done", pcu_pkg::ADDR_DONE_FLAGS, 32'h0);
      rd("tally", pcu_pkg::ADDR_EVENT_TALLY, 32'h0);
      trig(s[0], p);
      trig(s[0], ~p);
      rd("pos", pcu_pkg::ADDR_CAPT_POS, p);
      rd("tally", pcu_pkg::ADDR_EVENT_TALLY, 32'h1);
      rd("done", pcu_pkg::ADDR_DONE_FLAGS, 32'h1);
      rd("arm", pcu_pkg::ADDR_ARM_CONTROL, 32'h0);
      chk("armed", 33'h0, armed);
      chk("strobes", 33'(s + 1), n_stb);
      $display("test once %0d done", s);
    end
    wr(pcu_pkg::ADDR_ARM_CONTROL, 32'(pcu_pkg::ARM_CONT));
    for (int i = 1; i < 4; i++) begin
      p = rnd();
      trig(1'b1, p);
      rd("tally", pcu_pkg::ADDR_EVENT_TALLY, 32'(i));
      chk("armed", 33'h1, armed);
    end
    rd("pos", pcu_pkg::ADDR_CAPT_POS, p);
    chk("strobes", 33'h5, n_stb);
    wr(pcu_pkg::ADDR_ARM_CONTROL, 32'h3);
    rd("arm", pcu_pkg::ADDR_ARM_CONTROL, 32'h2);
    wr(pcu_pkg::ADDR_EDGE_SELECT, 32'h2);
    rd("edge", pcu_pkg::ADDR_EDGE_SELECT, 32'h1);
    q = rnd();
    @(negedge clk) pos <= '{rnd(), 1'b1, q};
    @(negedge clk) pos.rebase <= 1'b0;
    rd("rebased", pcu_pkg::ADDR_CAPT_POS, p + q);
    wr(pcu_pkg::ADDR_ARM_CONTROL, 32'(pcu_pkg::ARM_STOP));
    trig(1'b1, rnd());
    rd("tally", pcu_pkg::ADDR_EVENT_TALLY, 32'h3);
    chk("armed", 33'h0, armed);
    chk("strobes", 33'h5, n_stb);
    $display("test continuous done");
    close_out();
  end
endmodule : pcu_top_tb
`default_nettype wire
